// ### hw/chg_channel.sv
// Channel logic port: codec and telephone hybrid profiles with APB registers.
`timescale 1ns/1ps
// Operation
// - Codec talk-control-room mutes, routes preview speakers
// - Codec mute silences outputs, keeps on state
// - Codec talk-source input activates talk function
// - Codec on lamp: on, not talk/mute
// - Codec off lamp while channel off
// - Codec talk-control-room lamp while active
// - Codec mute lamp while mute active
// - Codec talk-source lamp while active
// - Hybrid preview command sets preview, lamp
// - Hybrid reset turns off, no stop
// - Hybrid ready lights the off lamp
// - Hybrid on/off lamps follow channel state
// - Hybrid start pulse 100 ms on turn-on/preview
// - Hybrid stop pulse 100 ms on off
module chg_channel #(
    parameter int PULSE_TICKS = chg_pkg::CHG_PULSE_TICKS,
    parameter int DEB_TICKS = chg_pkg::CHG_DEB_TICKS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command pins, active low
    input wire logic [4:0] cmd_b,
    // Open-collector lamp and pulse pins
    input wire logic [4:0] gpo_in,
    output logic [4:0] gpo_out,
    output logic [4:0] gpo_oe,
    // Audio path controls
    output logic chan_out_mute,
    output logic preview_speakers_route,
    output logic talk_back_source_act
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] ctrl_q;
    logic [6:0] tick_cnt_q;
    logic tick_q;
    logic [4:0] cmd_lvl;
    logic [4:0] cmd_prev_q;
    logic [4:0] cmd_ev;
    logic hyb;
    logic chan_on_q;
    logic preview_q;
    chg_pkg::chg_pulse_t pulse_st_q;
    logic [16:0] pulse_cnt_q;
    logic on_ev;
    logic off_ev;
    logic rst_ev;
    logic pvw_ev;
    logic talk_cr;
    logic mute_lvl;
    logic talk_src;
    logic ready_lvl;
    logic apb_setup;
    logic apb_wr;

    // Decode: a register offset is mapped when it is one of the three words.
    function automatic logic chg_hit(input logic [7:0] a);
        chg_hit = (a == chg_pkg::CHG_CTRL_OFS) || (a == chg_pkg::CHG_STAT_OFS) ||
                  (a == chg_pkg::CHG_CMD_OFS);
    endfunction

    assign hyb = ctrl_q[chg_pkg::CHG_CTRL_PROFILE];
    assign cmd_ev = cmd_lvl & ~cmd_prev_q;
    assign on_ev = cmd_ev[chg_pkg::CHG_IN_ON];
    assign off_ev = cmd_ev[chg_pkg::CHG_IN_OFF];
    assign rst_ev = hyb && cmd_ev[chg_pkg::CHG_IN_FN3];
    assign pvw_ev = hyb && cmd_ev[chg_pkg::CHG_IN_FN2];
    assign talk_cr = !hyb && cmd_lvl[chg_pkg::CHG_IN_FN2];
    assign mute_lvl = !hyb && cmd_lvl[chg_pkg::CHG_IN_FN3];
    // In the codec profile only, the console button bit and external input both drive talk_back_source.
    assign talk_src = !hyb && (cmd_lvl[chg_pkg::CHG_IN_FN4] ||
                      ctrl_q[chg_pkg::CHG_CTRL_TALK]);
    assign ready_lvl = hyb && cmd_lvl[chg_pkg::CHG_IN_FN4];
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pready && pwrite && !pslverr;

    ////////////////////////////////////////////////////////////////////////////
    // Divider giving a one-cycle 1 us enable for debounce and pulse timing.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_q <= 7'h00;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 7'(chg_pkg::CHG_TICK_CYC - 1)) begin
            tick_cnt_q <= 7'h00;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 7'h01;
            tick_q <= 1'b0;
        end
    end

    // Input cleaning; inputs are active low at the pins.
    chg_debounce #(
        .DEB_TICKS(DEB_TICKS)
    ) u_deb (
        .mclk(mclk),
        .rst_b(rst_b),
        .tick(tick_q),
        .raw_b(cmd_b),
        .level(cmd_lvl)
    );

    // Previous levels so that on, off, reset and preview act once per press.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_prev_q <= 5'h00;
        end else begin
            cmd_prev_q <= cmd_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel on state; off and reset outrank on when pressed together.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            chan_on_q <= 1'b0;
        end else if (off_ev || rst_ev) begin
            chan_on_q <= 1'b0;
        end else if (on_ev) begin
            chan_on_q <= 1'b1;
        end
    end

    // Preview latches on a press; leaving the hybrid profile or going on air clears it.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            preview_q <= 1'b0;
        end else if (!hyb || (on_ev && !off_ev && !rst_ev)) begin
            preview_q <= 1'b0;
        end else if (pvw_ev) begin
            preview_q <= 1'b1;
        end
    end

    // Timed pulses; a later event restarts the count so the newest one is reported.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_st_q <= chg_pkg::CHG_PIDLE;
            pulse_cnt_q <= 17'h00000;
        end else if (hyb && chan_on_q && off_ev && !rst_ev) begin
            pulse_st_q <= chg_pkg::CHG_PSTOP;
            pulse_cnt_q <= 17'h00000;
        end else if (hyb && ((!chan_on_q && on_ev && !off_ev && !rst_ev) ||
                     (pvw_ev && !preview_q))) begin
            pulse_st_q <= chg_pkg::CHG_PSTART;
            pulse_cnt_q <= 17'h00000;
        end else begin
            case (pulse_st_q)
                chg_pkg::CHG_PSTART, chg_pkg::CHG_PSTOP: begin
                    if (!hyb) begin
                        pulse_st_q <= chg_pkg::CHG_PIDLE;
                    end else if (tick_q) begin
                        if (pulse_cnt_q >= 17'(PULSE_TICKS - 1)) begin
                            pulse_st_q <= chg_pkg::CHG_PIDLE;
                            pulse_cnt_q <= 17'h00000;
                        end else begin
                            pulse_cnt_q <= pulse_cnt_q + 17'h00001;
                        end
                    end
                end
                chg_pkg::CHG_PIDLE: begin
                    pulse_cnt_q <= 17'h00000;
                end
                default: begin
                    pulse_st_q <= chg_pkg::CHG_PIDLE;
                    pulse_cnt_q <= 17'h00000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lamp and pulse pins; an enabled output sinks current and lights the lamp.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gpo_oe <= 5'h00;
            gpo_out <= 5'h00;
        end else if (hyb) begin
            gpo_out <= 5'h00;
            gpo_oe[chg_pkg::CHG_OUT_ON] <= chan_on_q;
            gpo_oe[chg_pkg::CHG_OUT_OFF] <= !chan_on_q || ready_lvl;
            gpo_oe[chg_pkg::CHG_OUT_L2] <= preview_q;
            gpo_oe[chg_pkg::CHG_OUT_L3] <= (pulse_st_q == chg_pkg::CHG_PSTART);
            gpo_oe[chg_pkg::CHG_OUT_L4] <= (pulse_st_q == chg_pkg::CHG_PSTOP);
        end else begin
            gpo_out <= 5'h00;
            gpo_oe[chg_pkg::CHG_OUT_ON] <= chan_on_q && !talk_cr && !mute_lvl &&
                                           !talk_src;
            gpo_oe[chg_pkg::CHG_OUT_OFF] <= !chan_on_q;
            gpo_oe[chg_pkg::CHG_OUT_L2] <= talk_cr;
            gpo_oe[chg_pkg::CHG_OUT_L3] <= mute_lvl;
            gpo_oe[chg_pkg::CHG_OUT_L4] <= talk_src;
        end
    end

    // Audio controls; mute never touches the on state, so unmuting restores output.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            chan_out_mute <= 1'b0;
            preview_speakers_route <= 1'b0;
            talk_back_source_act <= 1'b0;
        end else begin
            chan_out_mute <= talk_cr || mute_lvl;
            preview_speakers_route <= talk_cr || preview_q;
            talk_back_source_act <= talk_src;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register; only the two low bits are writable.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= chg_pkg::CHG_CTRL_RST;
        end else if (apb_wr && paddr == chg_pkg::CHG_CTRL_OFS) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    // Answer in the first access cycle: read data are captured at setup.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !chg_hit(paddr);
            prdata <= 32'h00000000;
            if (apb_setup && !pwrite) begin
                case (paddr)
                    chg_pkg::CHG_CTRL_OFS: prdata <= {30'h00000000, ctrl_q};
                    chg_pkg::CHG_STAT_OFS: prdata <= {19'h00000, gpo_in, pulse_st_q,
                                                      talk_src, mute_lvl, talk_cr,
                                                      preview_q, chan_on_q};
                    chg_pkg::CHG_CMD_OFS: prdata <= {27'h0000000, cmd_lvl};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks of the channel behaviour.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_off_wins_on: assert property (on_ev && off_ev |=> !chan_on_q)
        else $error("on and off together left channel on");
    a_on_sets_state: assert property (on_ev && !off_ev && !rst_ev |=> chan_on_q)
        else $error("on command did not turn channel on");
    a_reset_no_stop: assert property (
        pulse_st_q == chg_pkg::CHG_PIDLE && rst_ev && !on_ev && !pvw_ev |=>
        pulse_st_q == chg_pkg::CHG_PIDLE ##1 gpo_oe[chg_pkg::CHG_OUT_L4] == 1'b0)
        else $error("reset produced a stop pulse");
    a_stop_pulse_start: assert property (
        hyb && chan_on_q && off_ev && !rst_ev |=> ##1 gpo_oe[chg_pkg::CHG_OUT_L4])
        else $error("off command gave no stop pulse");
    a_start_pulse_start: assert property (
        hyb && !chan_on_q && on_ev && !off_ev && !rst_ev |=>
        ##1 gpo_oe[chg_pkg::CHG_OUT_L3] [*3])
        else $error("turn on gave no start pulse");
    a_pulse_bound: assert property (pulse_cnt_q < 17'(PULSE_TICKS))
        else $error("pulse counter ran past its length");
    a_mute_keeps_on: assert property (
        !hyb && $rose(mute_lvl) && !on_ev && !off_ev |=> $stable(chan_on_q)
        ##1 chan_out_mute)
        else $error("mute changed the on state or failed to mute");
    a_talk_cr_route: assert property (
        talk_cr |=> chan_out_mute && preview_speakers_route)
        else $error("talk to control room did not mute and route");
    a_codec_on_lamp: assert property (
        !hyb && $past(!hyb) && gpo_oe[chg_pkg::CHG_OUT_ON] |->
        $past(chan_on_q) && !$past(mute_lvl) && !$past(talk_cr) && !$past(talk_src))
        else $error("on lamp lit while muted, talking or off");
    a_hyb_off_lamp: assert property (
        hyb && (ready_lvl || !chan_on_q) |=> gpo_oe[chg_pkg::CHG_OUT_OFF])
        else $error("off lamp dark while off or ready");
    a_apb_answer: assert property (apb_setup |=> pready)
        else $error("setup cycle not answered in the next cycle");

    // Codec lamps trail their functions by one registered cycle.
    a_codec_off_lamp: assert property (
        !hyb && !chan_on_q |=> gpo_oe[chg_pkg::CHG_OUT_OFF])
        else $error("codec off lamp dark while channel off");
    a_codec_on_dark: assert property (
        !hyb && (talk_cr || mute_lvl || talk_src) |=> !gpo_oe[chg_pkg::CHG_OUT_ON])
        else $error("codec on lamp lit during talk or mute");
    a_talk_cr_lamp: assert property (
        talk_cr |=> gpo_oe[chg_pkg::CHG_OUT_L2])
        else $error("talk to control room lamp dark");
    a_mute_lamp: assert property (
        mute_lvl |=> gpo_oe[chg_pkg::CHG_OUT_L3] && chan_out_mute)
        else $error("mute lamp dark or outputs not muted");
    a_talk_src_lamp: assert property (
        talk_src |=> gpo_oe[chg_pkg::CHG_OUT_L4] && talk_back_source_act)
        else $error("talk_back_source lamp or function inactive");

    // Hybrid state, lamps and pulses; a profile change must leave no pulse behind.
    a_hyb_on_lamp: assert property (
        hyb && chan_on_q |=> gpo_oe[chg_pkg::CHG_OUT_ON])
        else $error("hybrid on lamp dark while channel on");
    a_preview_sets: assert property (
        pvw_ev && !on_ev |=> preview_q)
        else $error("preview command did not turn preview on");
    a_preview_lamp: assert property (
        hyb && preview_q |=> gpo_oe[chg_pkg::CHG_OUT_L2] && preview_speakers_route)
        else $error("preview lamp dark or preview not routed");
    a_preview_start: assert property (
        pvw_ev && !preview_q && !(chan_on_q && off_ev && !rst_ev) |=>
        pulse_st_q == chg_pkg::CHG_PSTART)
        else $error("first preview gave no start pulse");
    a_on_no_restart: assert property (
        hyb && chan_on_q && on_ev && !off_ev && !rst_ev && !pvw_ev &&
        pulse_st_q == chg_pkg::CHG_PIDLE |=> pulse_st_q == chg_pkg::CHG_PIDLE)
        else $error("on while already on gave a start pulse");
    a_reset_turns_off: assert property (
        rst_ev |=> !chan_on_q)
        else $error("reset command left channel on");
    a_codec_no_pulse: assert property (
        !hyb |=> pulse_st_q == chg_pkg::CHG_PIDLE)
        else $error("pulse running outside the hybrid profile");

    // Commands may only change on the slow tick, and idle read data must be zero.
    a_cmd_on_tick: assert property (
        $changed(cmd_lvl) |-> $past(tick_q))
        else $error("debounced command changed between ticks");
    a_rd_idle_zero: assert property (
        !pready |-> prdata == 32'h00000000)
        else $error("read data not zero outside an answer");

    c_stop_pulse: cover property (gpo_oe[chg_pkg::CHG_OUT_L4]);
    c_start_pulse: cover property (gpo_oe[chg_pkg::CHG_OUT_L3]);
    c_codec_mute: cover property (!hyb && mute_lvl && chan_on_q);
    c_bad_addr: cover property (pslverr && pready);
    c_preview_start: cover property (pvw_ev && !preview_q);
endmodule

// ### hw/chg_debounce.sv
// Synchroniser and debouncer for the five active-low command inputs.
`timescale 1ns/1ps
module chg_debounce #(
    parameter int DEB_TICKS = chg_pkg::CHG_DEB_TICKS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Slow timebase
    input wire logic tick,
    // Raw pins and cleaned active-high levels
    input wire logic [4:0] raw_b,
    output logic [4:0] level
);
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [9:0] cnt_q [5];

    // Two-flop synchroniser; the first stage feeds only the second.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 5'h1F;
            sync2_q <= 5'h1F;
        end else begin
            sync1_q <= raw_b;
            sync2_q <= sync1_q;
        end
    end

    // A level is accepted only after it held for DEB_TICKS ticks, so contact bounce is lost.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            level <= 5'h00;
            for (int i = 0; i < 5; i++) begin
                cnt_q[i] <= 10'h000;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (sync2_q[i] != level[i]) begin
                    cnt_q[i] <= 10'h000;
                end else if (tick) begin
                    if (cnt_q[i] >= 10'(DEB_TICKS - 1)) begin
                        level[i] <= ~sync2_q[i];
                        cnt_q[i] <= 10'h000;
                    end else begin
                        cnt_q[i] <= cnt_q[i] + 10'h001;
                    end
                end
            end
        end
    end
endmodule

// ### hw/chg_pkg.sv
// Constants and types shared by the channel logic port design.
package chg_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [7:0] CHG_CTRL_OFS = 8'h00;
    localparam logic [7:0] CHG_STAT_OFS = 8'h04;
    localparam logic [7:0] CHG_CMD_OFS = 8'h08;
    // Control register fields and reset value.
    localparam int CHG_CTRL_PROFILE = 0;
    localparam int CHG_CTRL_TALK = 1;
    localparam logic [1:0] CHG_CTRL_RST = 2'h0;
    // Command pin positions within the 5-bit input vector.
    localparam int CHG_IN_ON = 0;
    localparam int CHG_IN_OFF = 1;
    localparam int CHG_IN_FN2 = 2;
    localparam int CHG_IN_FN3 = 3;
    localparam int CHG_IN_FN4 = 4;
    // Output pin positions within the 5-bit lamp vector.
    localparam int CHG_OUT_ON = 0;
    localparam int CHG_OUT_OFF = 1;
    localparam int CHG_OUT_L2 = 2;
    localparam int CHG_OUT_L3 = 3;
    localparam int CHG_OUT_L4 = 4;
    // Timing: a 1 us tick drives every slow counter.
    localparam int CHG_CLK_NS = 10;
    localparam int CHG_TICK_NS = 1000;
    localparam int CHG_TICK_CYC = CHG_TICK_NS / CHG_CLK_NS;
    localparam int CHG_PULSE_MS = 100;
    localparam int CHG_PULSE_TICKS = CHG_PULSE_MS * 1000000 / CHG_TICK_NS;
    localparam int CHG_DEB_US = 1000;
    localparam int CHG_DEB_TICKS = CHG_DEB_US * 1000 / CHG_TICK_NS;
    // Timed output pulse state.
    typedef enum logic [2:0] {
        CHG_PIDLE = 3'b001,
        CHG_PSTART = 3'b010,
        CHG_PSTOP = 3'b100
    } chg_pulse_t;
endpackage

// ### tb/chg_equip.sv
// Model of the codec or hybrid equipment wired to the channel logic port.
`timescale 1ns/1ps
module chg_equip (
    // Buttons held by the bench, active high
    input wire logic [4:0] press,
    // Command pins toward the channel, active low
    output logic [4:0] cmd_b,
    // Open-collector pins from the channel and their wire levels
    input wire logic [4:0] gpo_out,
    input wire logic [4:0] gpo_oe,
    output logic [4:0] gpo_in
);
    ////////////////////////////////////////////////////////////////////////////////
    // A pressed contact pulls its pin low; the bench keeps each press past the debounce time, except the one short glitch press.
    assign cmd_b = ~press;
    // Every lamp line has a pull-up, so a released transistor reads high, not its last value.
    assign gpo_in = (gpo_oe & gpo_out) | ~gpo_oe;
endmodule

// ### tb/codec_hybrid_channel_gpio_tb.sv
// Self-checking bench for the channel logic port in codec and hybrid profiles.
`timescale 1ns/1ps
module codec_hybrid_channel_gpio_tb;
    // Short counts keep the run brief; every expectation derives from them.
    localparam int PT = 5;
    localparam int DT = 2;
    localparam int LO = (PT - 1) * 100;
    localparam int HI = (PT + 1) * 100;
    localparam int LIMIT = 40000;
    localparam logic [4:0] O_ON = 5'h01 << chg_pkg::CHG_OUT_ON;
    localparam logic [4:0] O_OFF = 5'h01 << chg_pkg::CHG_OUT_OFF;
    localparam logic [4:0] O_L2 = 5'h01 << chg_pkg::CHG_OUT_L2;
    localparam logic [4:0] O_L3 = 5'h01 << chg_pkg::CHG_OUT_L3;
    localparam logic [4:0] O_L4 = 5'h01 << chg_pkg::CHG_OUT_L4;
    localparam logic [4:0] I_ON = 5'h01 << chg_pkg::CHG_IN_ON;
    localparam logic [4:0] I_OFF = 5'h01 << chg_pkg::CHG_IN_OFF;
    localparam logic [4:0] I_F2 = 5'h01 << chg_pkg::CHG_IN_FN2;
    localparam logic [4:0] I_F3 = 5'h01 << chg_pkg::CHG_IN_FN3;
    localparam logic [4:0] I_F4 = 5'h01 << chg_pkg::CHG_IN_FN4;
    localparam logic [7:0] CTRL = chg_pkg::CHG_CTRL_OFS;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] press = 5'h00;
    logic [4:0] cmd_b;
    logic [4:0] gpo_in;
    logic [4:0] gpo_out;
    logic [4:0] gpo_oe;
    logic chan_out_mute;
    logic preview_speakers_route;
    logic talk_back_source_act;
    logic [31:0] rd;
    logic er;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    int start_len = 0;
    int stop_len = 0;
    int s0;

    ////////////////////////////////////////////////////////////////////////////////
    chg_channel #(.PULSE_TICKS(PT), .DEB_TICKS(DT)) DUT (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_b(cmd_b), .gpo_in(gpo_in), .gpo_out(gpo_out),
        .gpo_oe(gpo_oe), .chan_out_mute(chan_out_mute),
        .preview_speakers_route(preview_speakers_route),
        .talk_back_source_act(talk_back_source_act)
    );
    chg_equip equip (.press(press), .cmd_b(cmd_b), .gpo_out(gpo_out), .gpo_oe(gpo_oe),
        .gpo_in(gpo_in));

    always #5 mclk = ~mclk;

    // Pulse widths are summed here so a missing or stray pulse shows as a wrong total.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (gpo_oe[chg_pkg::CHG_OUT_L3] === 1'b1) start_len <= start_len + 1;
        if (gpo_oe[chg_pkg::CHG_OUT_L4] === 1'b1) stop_len <= stop_len + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared comparison, lamp comparison and pulse-length judgement.
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic oe(input string n, input logic [4:0] e);
        chk(n, {22'h0, gpo_out, gpo_oe}, {27'h0, e});
    endtask
    task automatic pl(input string n, input int d, input logic want);
        chk(n, want ? {31'h0, d >= LO && d <= HI} : d, want ? 32'h1 : 32'h0);
    endtask

    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Sets the buttons and waits past debounce, ending off the edge so outputs have settled.
    task automatic hold(input logic [4:0] m);
        @(posedge mclk);
        press <= m;
        repeat (400) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic print_verdict();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        apb(1'b0, CTRL, 32'h0);
        chk("ctrl_rst", rd, {30'h0, chg_pkg::CHG_CTRL_RST});
        oe("codec_rst", O_OFF);
        apb(1'b1, 8'h0C, 32'h1);
        chk("unmapped_wr_err", {31'h0, er}, 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped_rd", {rd[30:0], er}, 32'h1);
        // Codec profile: commands and lamps.
        hold(I_ON);
        oe("codec_on", O_ON);
        hold(I_F3);
        oe("codec_mute", O_L3);
        chk("mute_out", {31'h0, chan_out_mute}, 32'h1);
        apb(1'b0, chg_pkg::CHG_STAT_OFS, 32'h0);
        chk("mute_keeps_on", {31'h0, rd[0]}, 32'h1);
        chk("stat_mute_bit", {31'h0, rd[3]}, 32'h1);
        chk("gpo_readback", {27'h0, rd[12:8]}, {27'h0, ~O_L3});
        apb(1'b0, chg_pkg::CHG_CMD_OFS, 32'h0);
        chk("cmd_levels", rd, {27'h0, I_F3});
        hold(I_F2);
        oe("codec_talk_cr", O_L2);
        chk("talk_cr_audio", {30'h0, chan_out_mute, preview_speakers_route}, 32'h3);
        hold(I_F4);
        oe("codec_talk_src", O_L4);
        chk("talk_src_act", {31'h0, talk_back_source_act}, 32'h1);
        hold(5'h00);
        oe("codec_back_on", O_ON);
        // The console talk button in the control register acts like the talk input.
        apb(1'b1, CTRL, 32'h2);
        repeat (3) @(negedge mclk);
        oe("console_talk", O_L4);
        chk("console_talk_act", {31'h0, talk_back_source_act}, 32'h1);
        apb(1'b1, CTRL, 32'h0);
        // A press shorter than the debounce time must not act.
        @(posedge mclk);
        press <= I_OFF;
        repeat (50) @(posedge mclk);
        press <= 5'h00;
        hold(5'h00);
        oe("glitch_ignored", O_ON);
        hold(I_ON | I_OFF);
        oe("off_wins", O_OFF);
        hold(5'h00);
        // Hybrid profile: pulses, preview, reset and ready.
        apb(1'b1, CTRL, 32'h1);
        hold(5'h00);
        oe("hyb_off", O_OFF);
        s0 = start_len;
        hold(I_ON);
        hold(5'h00);
        oe("hyb_on", O_ON);
        pl("start_on", start_len - s0, 1'b1);
        s0 = start_len;
        hold(I_ON);
        hold(5'h00);
        pl("start_again", start_len - s0, 1'b0);
        s0 = stop_len;
        hold(I_OFF);
        hold(5'h00);
        oe("hyb_stop_off", O_OFF);
        pl("stop_off", stop_len - s0, 1'b1);
        s0 = start_len;
        hold(I_F2);
        hold(5'h00);
        oe("preview_lamp", O_OFF | O_L2);
        chk("preview_route", {31'h0, preview_speakers_route}, 32'h1);
        pl("start_preview", start_len - s0, 1'b1);
        hold(I_ON);
        hold(5'h00);
        s0 = stop_len;
        hold(I_F3);
        hold(5'h00);
        oe("reset_off", O_OFF);
        pl("reset_no_stop", stop_len - s0, 1'b0);
        hold(I_ON);
        hold(I_F4);
        oe("ready_lamp", O_ON | O_OFF);
        hold(5'h00);
        print_verdict();
    end
endmodule
